// >>> rtl/eip_unit.sv
// External interrupt pin unit: status and control register, request flag, pull control.
// Assumes an AHB-Lite master on sys_clk and an external pin asynchronous to it.
//
// Operation
// - Pull-disable bit 6 turns internal pull off.
// - Polarity bit 5: zero falling/low, one rising/high.
// - Enabled rising polarity applies a pull-down.
// - Enabled falling polarity applies a pull-up.
// - Pin-enable bit 4 gates request source.
// - Read-only request flag at bit 3.
// - Writing one to bit 2 clears flag.
// - Level mode keeps flag while pin asserted.
// - Interrupt-enable bit 1 gates processor request.
// - Mode bit 0: edges only or edge+level.
`timescale 1ns/1ns
`include "eip_defs.svh"

module eip_unit
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        pin_in,
    output logic             pin_pull_up_en,
    output logic             pin_pull_down_en,
    output logic             cpu_irq,
    output logic             unit_irq
);

    logic [7:0]                 ctrl_q;
    logic                       flag_q;
    logic [`EIP_EVT_WIDTH-1:0]  evt_status_q;
    logic [`EIP_EVT_WIDTH-1:0]  evt_mask_q;
    logic [31:0]                hrdata_q;
    logic                       cpu_irq_q;
    logic                       unit_irq_q;
    logic                       pull_up_q;
    logic                       pull_down_q;
    logic [7:0]                 wr_addr_q;
    eip_pkg::eip_bus_state_t    bus_state_q;
    logic                       addr_phase;
    logic                       wr_en;
    logic [7:0]                 wdata8;
    logic                       pin_asserted;
    logic                       pin_event;
    logic                       ack_wr;
    logic                       flag_set;
    logic                       flag_rise;
    logic                       ovr_evt;
    logic [`EIP_EVT_WIDTH-1:0]  evt_now;
    logic [7:0]                 ctrl_rd;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction

    eip_pin_detect
    #(
        .SYNC_STAGES         (`EIP_SYNC_STAGES)
    )
    u_detect
    (
        .sys_clk             (sys_clk),
        .nrst                (nrst),
        .pin_in              (pin_in),
        .pin_function_enable (ctrl_q[`EIP_BIT_PIN_ENABLE]),
        .pin_polarity_select (ctrl_q[`EIP_BIT_POLARITY]),
        .pin_detection_mode  (ctrl_q[`EIP_BIT_MODE]),
        .pin_asserted        (pin_asserted),
        .pin_event           (pin_event)
    );

    // Bus slave: zero wait states, registered read data, write data taken in its data phase.
    assign addr_phase = hsel & hready & htrans[1];
    assign wr_en      = (bus_state_q == eip_pkg::EIP_BUS_WRITE);
    assign wdata8     = hwdata[7:0];

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_addr_q   <= 8'h00;
            bus_state_q <= eip_pkg::EIP_BUS_IDLE;
        end
        else
        begin
            if (addr_phase)
            begin
                wr_addr_q <= haddr;
            end
            case (bus_state_q)
                eip_pkg::EIP_BUS_IDLE,
                eip_pkg::EIP_BUS_WRITE,
                eip_pkg::EIP_BUS_READ:
                begin
                    if (!addr_phase)
                    begin
                        bus_state_q <= eip_pkg::EIP_BUS_IDLE;
                    end
                    else if (hwrite)
                    begin
                        bus_state_q <= eip_pkg::EIP_BUS_WRITE;
                    end
                    else
                    begin
                        bus_state_q <= eip_pkg::EIP_BUS_READ;
                    end
                end
                default:
                begin
                    bus_state_q <= eip_pkg::EIP_BUS_IDLE;
                end
            endcase
        end
    end

    // Control bits; the flag and the acknowledge bit are not storage here.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= `EIP_CTRL_RESET;
        end
        else if (wr_en && is_reg(wr_addr_q, `EIP_CTRL_OFFSET))
        begin
            ctrl_q <= wdata8 & `EIP_CTRL_WMASK;
        end
    end

    // Acknowledge only on a written one; a zero does nothing.
    assign ack_wr   = wr_en && is_reg(wr_addr_q, `EIP_CTRL_OFFSET)
                      && wdata8[`EIP_BIT_ACK];
    assign flag_set = pin_event;

    // A set in the same cycle as an acknowledge wins, and in level mode the held level
    // re-sets the flag through pin_event, so an acknowledge cannot clear it.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_q <= 1'b0;
        end
        else if (flag_set)
        begin
            flag_q <= 1'b1;
        end
        else if (ack_wr)
        begin
            flag_q <= 1'b0;
        end
    end

    assign flag_rise = flag_set & ~flag_q;
    assign ovr_evt   = flag_set & flag_q & ~ctrl_q[`EIP_BIT_MODE];
    assign evt_now   = {ovr_evt, flag_rise};

    // Sticky event status, cleared by writing one; a new event beats the clear.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            evt_status_q <= `EIP_EVT_RESET;
            evt_mask_q   <= `EIP_EVT_RESET;
        end
        else
        begin
            if (wr_en && is_reg(wr_addr_q, `EIP_IRQ_STATUS_OFFSET))
            begin
                evt_status_q <= (evt_status_q & ~wdata8[`EIP_EVT_WIDTH-1:0]) | evt_now;
            end
            else
            begin
                evt_status_q <= evt_status_q | evt_now;
            end
            if (wr_en && is_reg(wr_addr_q, `EIP_IRQ_MASK_OFFSET))
            begin
                evt_mask_q <= wdata8[`EIP_EVT_WIDTH-1:0];
            end
        end
    end

    // Pull selection follows polarity; disabled pin or pull-disable means no pull.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pull_up_q   <= 1'b0;
            pull_down_q <= 1'b0;
        end
        else
        begin
            pull_down_q <= ctrl_q[`EIP_BIT_PIN_ENABLE] & ~ctrl_q[`EIP_BIT_PULL_DIS]
                           & ctrl_q[`EIP_BIT_POLARITY];
            pull_up_q   <= ctrl_q[`EIP_BIT_PIN_ENABLE] & ~ctrl_q[`EIP_BIT_PULL_DIS]
                           & ~ctrl_q[`EIP_BIT_POLARITY];
        end
    end

    // Interrupt outputs are registered so that every top output except the tied-off hreadyout and hresp leaves a flip-flop.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cpu_irq_q  <= 1'b0;
            unit_irq_q <= 1'b0;
        end
        else
        begin
            cpu_irq_q  <= (flag_q | flag_set) & ctrl_q[`EIP_BIT_INT_ENABLE];
            unit_irq_q <= |((evt_status_q | evt_now) & evt_mask_q);
        end
    end

    // The acknowledge bit always reads zero.
    always_comb
    begin
        ctrl_rd                  = ctrl_q;
        ctrl_rd[`EIP_BIT_FLAG]   = flag_q;
        ctrl_rd[`EIP_BIT_ACK]    = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hrdata_q <= 32'h0000_0000;
        end
        else if (addr_phase && !hwrite)
        begin
            if (is_reg(haddr, `EIP_CTRL_OFFSET))
            begin
                hrdata_q <= {24'h00_0000, ctrl_rd};
            end
            else if (is_reg(haddr, `EIP_IRQ_STATUS_OFFSET))
            begin
                hrdata_q <= {30'h0000_0000, evt_status_q};
            end
            else if (is_reg(haddr, `EIP_IRQ_MASK_OFFSET))
            begin
                hrdata_q <= {30'h0000_0000, evt_mask_q};
            end
            else
            begin
                hrdata_q <= 32'h0000_0000;
            end
        end
    end

    assign hrdata           = hrdata_q;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign pin_pull_up_en   = pull_up_q;
    assign pin_pull_down_en = pull_down_q;
    assign cpu_irq          = cpu_irq_q;
    assign unit_irq         = unit_irq_q;

    a_pull_disabled_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(ctrl_q[`EIP_BIT_PULL_DIS]) |-> !pin_pull_up_en && !pin_pull_down_en)
        else $error("Pull active although pull is disabled.");

    a_pull_down_rise: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ($past(ctrl_q) & 8'h70) == 8'h30 |-> pin_pull_down_en && !pin_pull_up_en)
        else $error("Rising polarity did not give a pull-down.");

    a_pull_up_fall: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 ($past(ctrl_q) & 8'h70) == 8'h10 |-> pin_pull_up_en && !pin_pull_down_en)
        else $error("Falling polarity did not give a pull-up.");

    a_disabled_no_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        !ctrl_q[`EIP_BIT_PIN_ENABLE] && !flag_q |=> !flag_q)
        else $error("Flag set while the pin function is disabled.");

    a_ack_reads_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(addr_phase && !hwrite) |-> !hrdata[`EIP_BIT_ACK])
        else $error("Acknowledge bit read back as one.");

    a_ack_clears_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        ack_wr && !pin_event |=> !flag_q)
        else $error("Acknowledge did not clear the flag.");

    a_level_holds_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        ack_wr && ctrl_q[`EIP_BIT_MODE] && pin_asserted |=> flag_q)
        else $error("Flag cleared while level still asserted.");

    a_irq_follows_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        flag_q && ctrl_q[`EIP_BIT_INT_ENABLE] && $stable(ctrl_q) |=> ##[0:1] cpu_irq)
        else $error("Enabled flag raised no processor request.");

    a_irq_gated_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(ctrl_q[`EIP_BIT_INT_ENABLE]) |-> !cpu_irq)
        else $error("Processor request raised while disabled.");

    a_set_beats_ack: assert property (@(posedge sys_clk) disable iff (!nrst)
        ack_wr && pin_event |=> flag_q)
        else $error("Detected event lost to an acknowledge.");

    a_pull_exclusive: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(pin_pull_up_en && pin_pull_down_en))
        else $error("Pull-up and pull-down active together.");

    a_pull_off_disabled: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(ctrl_q[`EIP_BIT_PIN_ENABLE]) |-> !pin_pull_up_en && !pin_pull_down_en)
        else $error("Pull active while the pin function is disabled.");

    a_ack_zero_inert: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_en && is_reg(wr_addr_q, `EIP_CTRL_OFFSET) && !wdata8[`EIP_BIT_ACK] && flag_q
        |=> flag_q)
        else $error("Writing zero to the acknowledge bit cleared the flag.");

    a_flag_needs_event: assert property (@(posedge sys_clk) disable iff (!nrst)
        !flag_q && !pin_event |=> !flag_q)
        else $error("Flag set without a detected event.");

    a_event_sets_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        pin_event |=> flag_q)
        else $error("Detected event did not set the flag.");

    a_irq_needs_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(flag_q) && !$past(pin_event) |-> !cpu_irq)
        else $error("Processor request raised without a flag.");

    a_flag_reads_back: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(addr_phase && !hwrite && haddr == `EIP_CTRL_OFFSET)
        |-> hrdata[`EIP_BIT_FLAG] == $past(flag_q))
        else $error("Flag read back wrongly.");

    a_edge_no_repeat: assert property (@(posedge sys_clk) disable iff (!nrst)
        !ctrl_q[`EIP_BIT_MODE] && pin_asserted && $past(pin_asserted) && $stable(ctrl_q)
        |-> !pin_event)
        else $error("Held level raised an event in edge-only mode.");

    a_level_sets_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
        ctrl_q[`EIP_BIT_MODE] && pin_asserted |=> flag_q)
        else $error("Asserted level did not set the flag in level mode.");

endmodule

// >>> rtl/eip_defs.svh
// Offsets, field positions, reset values and timing counts of the external interrupt pin unit.
// Included by the unit's modules; holds definitions only.
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH

`define EIP_CTRL_OFFSET        8'h00
`define EIP_IRQ_STATUS_OFFSET  8'h04
`define EIP_IRQ_MASK_OFFSET    8'h08

`define EIP_BIT_POLARITY       3'd5
`define EIP_BIT_PIN_ENABLE     3'd4
`define EIP_BIT_FLAG           3'd3
`define EIP_BIT_ACK            3'd2
`define EIP_BIT_INT_ENABLE     3'd1
`define EIP_BIT_MODE           3'd0
`define EIP_BIT_PULL_DIS       3'd6

`define EIP_CTRL_RESET         8'h00
`define EIP_CTRL_WMASK         8'h73
`define EIP_EVT_WIDTH          2
`define EIP_EVT_RESET          2'h0

`define EIP_CLK_PERIOD_NS      50
`define EIP_SYNC_STAGES        2

`endif

// >>> rtl/eip_pkg.sv
// Types shared by the external interrupt pin unit.
// Assumes eip_defs.svh supplies the numeric constants.
package eip_pkg;

    typedef enum logic [2:0]
    {
        EIP_BUS_IDLE  = 3'b001,
        EIP_BUS_WRITE = 3'b010,
        EIP_BUS_READ  = 3'b100
    } eip_bus_state_t;

    typedef enum logic [1:0]
    {
        EIP_PULL_UP   = 2'b01,
        EIP_PULL_DOWN = 2'b10
    } eip_pull_t;

endpackage

// >>> rtl/eip_pin_detect.sv
// Pin synchroniser and event detector of the external interrupt pin unit.
// Assumes the pin is asynchronous to sys_clk; the configuration inputs are sys_clk registers.
`timescale 1ns/1ns
`include "eip_defs.svh"

module eip_pin_detect
#(
    parameter int SYNC_STAGES = `EIP_SYNC_STAGES
)
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic pin_in,
    input  wire logic pin_function_enable,
    input  wire logic pin_polarity_select,
    input  wire logic pin_detection_mode,
    output logic      pin_asserted,
    output logic      pin_event
);

    logic [SYNC_STAGES-1:0] sync_q;
    logic                   prev_q;
    logic                   level_now;
    logic                   level_prev;

    if (SYNC_STAGES < 2)
    begin : g_stage_check
        $error("eip_pin_detect needs at least two synchroniser stages");
    end

    // The first stage only ever feeds the second, so metastability stays contained.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // Reset to the idle high level of the default falling polarity, so no false edge.
            sync_q <= '1;
            prev_q <= 1'b1;
        end
        else
        begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], pin_in};
            prev_q <= sync_q[SYNC_STAGES-1];
        end
    end

    // Fold polarity in so that one means asserted in both senses.
    assign level_now    = sync_q[SYNC_STAGES-1] ^ ~pin_polarity_select;
    assign level_prev   = prev_q ^ ~pin_polarity_select;
    assign pin_asserted = pin_function_enable & level_now;

    // An edge is two consecutive synchronised samples that differ toward asserted.
    // Both samples fold in the current polarity, so flipping the bit makes no edge; in level mode it can still set the flag.
    assign pin_event = pin_function_enable
                     & ((level_now & ~level_prev)
                     | (pin_detection_mode & level_now));

endmodule

// >>> verification/eip_pin_driver.sv
// Model of the external device on the interrupt pin, with the pin's pull network.
// Assumes the bench changes drive_en and drive_val just after sys_clk rising edges.
`timescale 1ns/1ns

module eip_pin_driver
(
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    output logic      pin
);
    logic last_q = 1'b0;

    always @(drive_en or drive_val)
    begin
        if (drive_en)
            last_q = drive_val;
    end

    // A released pin with no pull is undefined, so it shows the inverse of the last level.
    always_comb
    begin
        if (drive_en)
            pin = drive_val;
        else if (pull_up_en)
            pin = 1'b1;
        else if (pull_down_en)
            pin = 1'b0;
        else
            pin = ~last_q;
    end
endmodule

// >>> verification/external_interrupt_pin_unit_test.sv
// Self-checking bench of the external interrupt pin unit.
// Assumes the unit answers AHB-Lite without wait states and the pin model above.
`timescale 1ns/1ns

module external_interrupt_pin_unit_test;
    logic        sys_clk;
    logic        nrst;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_in;
    logic        pin_pull_up_en;
    logic        pin_pull_down_en;
    logic        cpu_irq;
    logic        unit_irq;
    logic        drv_en;
    logic        drv_val;
    int          error_cnt;
    int          comparisons;

    eip_unit uut
    (
        .sys_clk          (sys_clk),
        .nrst             (nrst),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hwdata           (hwdata),
        .hready           (hreadyout),
        .hrdata           (hrdata),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .pin_in           (pin_in),
        .pin_pull_up_en   (pin_pull_up_en),
        .pin_pull_down_en (pin_pull_down_en),
        .cpu_irq          (cpu_irq),
        .unit_irq         (unit_irq)
    );

    eip_pin_driver far_end
    (
        .drive_en     (drv_en),
        .drive_val    (drv_val),
        .pull_up_en   (pin_pull_up_en),
        .pull_down_en (pin_pull_down_en),
        .pin          (pin_in)
    );

    always #25 sys_clk = ~sys_clk;

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; waits on hready in both phases.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, {24'h0, exp});
    endtask

    task automatic pin(input logic v);
        drv_val <= v;
        repeat (5) @(posedge sys_clk);
    endtask

    // Checks {pull-up, pull-down, cpu_irq, unit_irq} where outputs have settled.
    task automatic po(input logic [3:0] exp);
        @(negedge sys_clk);
        chk({28'h0, pin_pull_up_en, pin_pull_down_en, cpu_irq, unit_irq}, {28'h0, exp});
        @(posedge sys_clk);
    endtask

    task automatic t_reset();
        rdc(8'h00, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h08, 8'h00);
        rdc(8'h0c, 8'h00);
        po(4'h0);
    endtask

    task automatic t_pulls();
        logic [7:0] cv[5];
        logic [1:0] pv[5];
        cv = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h20};
        pv = '{2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h00, cv[i]);
            @(posedge sys_clk);
            po({pv[i], 2'b00});
        end
    endtask

    task automatic t_fall();
        pin(1'b1);
        wr(8'h00, 8'h16);
        wr(8'h04, 8'h03);
        rdc(8'h00, 8'h12);
        pin(1'b0);
        rdc(8'h00, 8'h1a);
        po(4'b1010);
        wr(8'h00, 8'h12);
        rdc(8'h00, 8'h1a);
        wr(8'h00, 8'h10);
        @(posedge sys_clk);
        po(4'b1000);
        wr(8'h00, 8'h14);
        rdc(8'h00, 8'h10);
        pin(1'b1);
        rdc(8'h00, 8'h10);
    endtask

    task automatic t_status();
        wr(8'h04, 8'h03);
        wr(8'h08, 8'h03);
        pin(1'b0);
        po(4'b1001);
        pin(1'b1);
        pin(1'b0);
        rdc(8'h04, 8'h03);
        wr(8'h08, 8'h00);
        @(posedge sys_clk);
        po(4'b1000);
        wr(8'h04, 8'h01);
        rdc(8'h04, 8'h02);
        wr(8'h04, 8'h02);
        wr(8'h08, 8'h03);
        po(4'b1000);
    endtask

    task automatic t_rise();
        wr(8'h00, 8'h34);
        wr(8'h04, 8'h03);
        rdc(8'h00, 8'h30);
        pin(1'b1);
        rdc(8'h00, 8'h38);
        wr(8'h00, 8'h34);
        rdc(8'h00, 8'h30);
        pin(1'b0);
        rdc(8'h00, 8'h30);
        wr(8'h00, 8'h35);
        rdc(8'h00, 8'h31);
        pin(1'b1);
        wr(8'h00, 8'h35);
        rdc(8'h00, 8'h39);
        pin(1'b0);
        wr(8'h00, 8'h35);
        rdc(8'h00, 8'h31);
    endtask

    task automatic t_off();
        wr(8'h00, 8'h04);
        pin(1'b1);
        pin(1'b0);
        rdc(8'h00, 8'h00);
    endtask

    // A released pin must be held inactive by the pull; without it the model floats
    // to the opposite level and the unit would see a false event.
    task automatic t_release();
        wr(8'h00, 8'h30);
        pin(1'b0);
        drv_en <= 1'b0;
        pin(1'b0);
        rdc(8'h00, 8'h30);
        drv_en <= 1'b1;
        wr(8'h00, 8'h10);
        pin(1'b1);
        drv_en <= 1'b0;
        pin(1'b1);
        rdc(8'h00, 8'h10);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        drv_en = 1'b1;
        drv_val = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_pulls();
        t_fall();
        t_status();
        t_rise();
        t_off();
        t_release();
        complete_run();
    end

    // The scenarios take well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end
endmodule
